/* File: rtl/quad_adc_output.sv */
// Purpose: Output side of a quad 10-bit converter: sampling slots, input routing,
//          coding, out-of-range flags, data-ready strobe and resynchronisation.
// Assumes: Raw samples arrive already digitised on the converter clock; the
//          configuration is written on the core clock by the control port.
// Notes:   The converter clock is a second domain; configuration crosses as levels.
//
// Notes on behaviour
// R1 - Per-channel rate: 1250, 2500, 5000 Msps in four, two, one channel mode; the code gives one channel mode the two channel rate, one sample per clock.
// R2 - The far side holds resync high across at least two converter clock edges.
// R3 - Data-ready rising edge sits mid data window, half a clock after data; the code raises it 1.5 clocks after data.
// R4 - After resync the data-ready strobe resets after about 2.5 ns; the code clears it on the next falling edge.
// R5 - Two channel mode: first input on ports A,B; second on ports C,D.
// R6 - Two channel mode accepts pairings A-C, A-D, B-C and B-D.
// R7 - One channel mode digitises whichever input the control field selects.
// R8 - Latency uniform in four channel mode, differs by group or port otherwise.
// R9 - Each port gives a binary or Gray code plus an out-of-range flag.
// R10 - Sampling slots come from the converter clock divided by two.

`timescale 1ns/1ps

module quad_adc_output (
    // Core clock and reset
    input  wire logic                              core_clk_i,
    input  wire logic                              sys_rst_i,
    // Configuration, core domain
    input  wire quad_adc_pkg::chan_mode_t          mode_i,
    input  wire logic                              pair_first_b_i,
    input  wire logic                              pair_second_d_i,
    input  wire quad_adc_pkg::input_sel_t          single_sel_i,
    input  wire logic                              gray_code_i,
    // Converter clock and raw samples, converter domain
    input  wire logic                              conv_clk_i,
    input  wire logic signed [quad_adc_pkg::RAW_W-1:0] raw_a_i,
    input  wire logic signed [quad_adc_pkg::RAW_W-1:0] raw_b_i,
    input  wire logic signed [quad_adc_pkg::RAW_W-1:0] raw_c_i,
    input  wire logic signed [quad_adc_pkg::RAW_W-1:0] raw_d_i,
    // Resynchronisation pins
    input  wire logic                              resync_in_pos_i,
    input  wire logic                              resync_in_neg_i,
    // Output ports
    output logic [quad_adc_pkg::CODE_W-1:0]        port_a_o,
    output logic [quad_adc_pkg::CODE_W-1:0]        port_b_o,
    output logic [quad_adc_pkg::CODE_W-1:0]        port_c_o,
    output logic [quad_adc_pkg::CODE_W-1:0]        port_d_o,
    output logic [quad_adc_pkg::NUM_PORTS-1:0]     out_of_range_o,
    output logic                                   data_ready_pos_o,
    output logic                                   data_ready_neg_o,
    // Status, core domain
    output logic                                   resync_seen_o
);
    import quad_adc_pkg::*;

    // ------------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------------

    // Clamp a signed raw value into the code range.
    function automatic logic [CODE_W-1:0] clamp_code(input logic signed [RAW_W-1:0] raw);
        logic signed [RAW_W-1:0] biased;
        biased = raw + RAW_W'(CODE_MID);
        if (biased > $signed(RAW_W'(CODE_TOP))) begin
            clamp_code = CODE_TOP;
        end else if (biased < $signed(RAW_W'(CODE_BOTTOM))) begin
            clamp_code = CODE_BOTTOM;
        end else begin
            clamp_code = biased[CODE_W-1:0];
        end
    endfunction

    // Flag a raw value beyond either end of full scale.
    function automatic logic out_of_scale(input logic signed [RAW_W-1:0] raw);
        logic signed [RAW_W-1:0] biased;
        biased = raw + RAW_W'(CODE_MID);
        out_of_scale = (biased > $signed(RAW_W'(CODE_TOP)))
                    || (biased < $signed(RAW_W'(CODE_BOTTOM)));
    endfunction

    // Binary to reflected Gray.
    function automatic logic [CODE_W-1:0] to_gray(input logic [CODE_W-1:0] bin);
        to_gray = bin ^ (bin >> 1);
    endfunction

    // ------------------------------------------------------------------
    // Core-domain configuration holding
    // ------------------------------------------------------------------
    chan_mode_t mode_reg;
    logic       first_b_reg;
    logic       second_d_reg;
    input_sel_t single_sel_reg;
    logic       gray_reg;

    // Configuration is registered so the crossing sees flop outputs only.
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            mode_reg       <= MODE_4CH;
            first_b_reg    <= 1'b0;
            second_d_reg   <= 1'b0;
            single_sel_reg <= 2'h0;
            gray_reg       <= 1'b0;
        end else begin
            mode_reg       <= (mode_i == MODE_2CH || mode_i == MODE_1CH) ? mode_i : MODE_4CH;
            first_b_reg    <= pair_first_b_i;                 // [R6]
            second_d_reg   <= pair_second_d_i;                // [R6]
            single_sel_reg <= single_sel_i;                   // [R7]
            gray_reg       <= gray_code_i;
        end
    end

    // ------------------------------------------------------------------
    // Crossing into the converter domain
    // ------------------------------------------------------------------
    localparam int CFG_W = 7;
    logic [CFG_W-1:0] cfg_meta_reg;
    logic [CFG_W-1:0] cfg_sync_reg;
    logic [CFG_W-1:0] cfg_hold_reg;
    logic [CFG_W-1:0] cfg_use_reg;
    logic [1:0]       rst_sync_reg;
    logic             conv_rst;

    // Static configuration crosses as levels; bits could land one edge apart.
    always_ff @(posedge conv_clk_i) begin
        cfg_meta_reg <= {mode_reg, first_b_reg, second_d_reg, single_sel_reg, gray_reg};
        cfg_sync_reg <= cfg_meta_reg;
    end

    // The word is used only once two edges agree, so a skewed mix of old and new
    // bits never reaches the routing; this costs two edges of latency.
    always_ff @(posedge conv_clk_i) begin
        cfg_hold_reg <= cfg_sync_reg;
        if (conv_rst) begin
            cfg_use_reg <= '0;
        end else if (cfg_sync_reg == cfg_hold_reg) begin
            cfg_use_reg <= cfg_hold_reg;
        end
    end

    // Reset level crossed into the converter domain.
    always_ff @(posedge conv_clk_i) begin
        rst_sync_reg <= {rst_sync_reg[0], sys_rst_i};
    end
    assign conv_rst = rst_sync_reg[1];

    chan_mode_t cv_mode;
    logic       cv_first_b;
    logic       cv_second_d;
    input_sel_t cv_single;
    logic       cv_gray;

    assign cv_mode     = chan_mode_t'(cfg_use_reg[6:5]);
    assign cv_first_b  = cfg_use_reg[4];
    assign cv_second_d = cfg_use_reg[3];
    assign cv_single   = cfg_use_reg[2:1];
    assign cv_gray     = cfg_use_reg[0];

    // ------------------------------------------------------------------
    // Resynchronisation input
    // ------------------------------------------------------------------
    logic [1:0] rs_pos_reg;
    logic [1:0] rs_neg_reg;
    logic [1:0] rs_width_reg;
    logic       resync_hit;

    // Both pin halves pass two flip-flops before any logic reads them.
    always_ff @(posedge conv_clk_i) begin
        rs_pos_reg <= {rs_pos_reg[0], resync_in_pos_i};
        rs_neg_reg <= {rs_neg_reg[0], resync_in_neg_i};
    end

    // A pulse counts only once it has been high for the least width, so a glitch
    // shorter than that does not disturb the slot phase.
    always_ff @(posedge conv_clk_i) begin
        if (conv_rst) begin
            rs_width_reg <= 2'h0;
        end else if (rs_pos_reg[1] && !rs_neg_reg[1]) begin
            if (rs_width_reg != 2'(RESYNC_MIN_WIDTH)) begin
                rs_width_reg <= rs_width_reg + 2'h1;          // [R2]
            end
        end else begin
            rs_width_reg <= 2'h0;
        end
    end
    assign resync_hit = (rs_width_reg == 2'(RESYNC_MIN_WIDTH - 1))
                     && rs_pos_reg[1] && !rs_neg_reg[1];      // [R2]

    // ------------------------------------------------------------------
    // Sampling slots
    // ------------------------------------------------------------------
    logic [1:0] slot_reg;

    // Bit 0 is the converter clock divided by two; bit 1 lets one channel mode
    // interleave all four cores.
    always_ff @(posedge conv_clk_i) begin
        if (conv_rst || resync_hit) begin
            slot_reg <= 2'h0;
        end else begin
            slot_reg <= slot_reg + 2'h1;                      // [R10]
        end
    end

    // Capture enable per core: one rate per mode.
    function automatic logic core_takes(input chan_mode_t m, input logic [1:0] slot,
                                        input int core);
        unique case (m)
            MODE_4CH: core_takes = (slot[0] == 1'b0);                       // [R1] [R10]
            MODE_2CH: core_takes = (slot[0] == core[0]);                    // [R1] [R8]
            MODE_1CH: core_takes = (slot == core[1:0]);                     // [R1] [R8]
            default:  core_takes = 1'b0;
        endcase
    endfunction

    // Input seen by each core.
    function automatic input_sel_t core_source(input chan_mode_t m, input int core,
                                               input logic fb, input logic sd,
                                               input input_sel_t one);
        unique case (m)
            MODE_4CH: core_source = core[1:0];
            MODE_2CH: core_source = (core < 2) ? {1'b0, fb} : {1'b1, sd};   // [R5] [R6]
            MODE_1CH: core_source = one;                                    // [R7]
            default:  core_source = core[1:0];
        endcase
    endfunction

    // ------------------------------------------------------------------
    // Output ports
    // ------------------------------------------------------------------
    logic signed [RAW_W-1:0] raw_in [NUM_PORTS];
    logic [CODE_W-1:0]       port_reg [NUM_PORTS];
    logic [NUM_PORTS-1:0]    oor_reg;

    assign raw_in[0] = raw_a_i;
    assign raw_in[1] = raw_b_i;
    assign raw_in[2] = raw_c_i;
    assign raw_in[3] = raw_d_i;

    // Each core updates its own port in its own slot, so latency per port follows
    // the slot order of the mode.
    always_ff @(posedge conv_clk_i) begin
        if (conv_rst) begin
            for (int k = 0; k < NUM_PORTS; k++) begin
                port_reg[k] <= CODE_BOTTOM;
            end
            oor_reg <= '0;
        end else begin
            for (int k = 0; k < NUM_PORTS; k++) begin
                if (core_takes(cv_mode, slot_reg, k)) begin
                    port_reg[k] <= cv_gray                                      // [R9]
                        ? to_gray(clamp_code(raw_in[core_source(cv_mode, k, cv_first_b,
                                                            cv_second_d, cv_single)]))
                        : clamp_code(raw_in[core_source(cv_mode, k, cv_first_b,
                                                        cv_second_d, cv_single)]);
                    oor_reg[k]  <= out_of_scale(raw_in[core_source(cv_mode, k,     // [R9]
                                        cv_first_b, cv_second_d, cv_single)]);
                end
            end
        end
    end

    assign port_a_o       = port_reg[0];
    assign port_b_o       = port_reg[1];
    assign port_c_o       = port_reg[2];
    assign port_d_o       = port_reg[3];
    assign out_of_range_o = oor_reg;

    // ------------------------------------------------------------------
    // Data-ready strobe
    // ------------------------------------------------------------------
    logic dr_reg;

    // Launched on the falling edge: the rise comes 1.5 periods after the data edge and
    // half a period before the next one in four channel mode, so setup exceeds hold.
    always_ff @(negedge conv_clk_i) begin
        if (conv_rst || resync_hit) begin
            dr_reg <= 1'b0;                                   // [R4]
        end else begin
            dr_reg <= ~slot_reg[0];                           // [R3]
        end
    end

    assign data_ready_pos_o = dr_reg;                         // [R3]
    assign data_ready_neg_o = ~dr_reg;

    // ------------------------------------------------------------------
    // Resync report back to the core domain
    // ------------------------------------------------------------------
    logic       rs_toggle_reg;
    logic [2:0] rs_back_reg;
    logic       seen_reg;

    // Event crosses as a toggle.
    always_ff @(posedge conv_clk_i) begin
        if (conv_rst) begin
            rs_toggle_reg <= 1'b0;
        end else if (resync_hit) begin
            rs_toggle_reg <= ~rs_toggle_reg;
        end
    end

    // One-cycle pulse in the core domain per accepted resync.
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            rs_back_reg <= 3'h0;
            seen_reg    <= 1'b0;
        end else begin
            rs_back_reg <= {rs_back_reg[1:0], rs_toggle_reg};
            seen_reg    <= rs_back_reg[2] ^ rs_back_reg[1];
        end
    end
    assign resync_seen_o = seen_reg;

endmodule // quad_adc_output

/* File: rtl/quad_adc_pkg.sv */
// Purpose: Shared constants and types for the quad converter output routing block.
// Assumes: One core clock for configuration and one converter clock for the output side.
// Notes:   Times are kept in their own unit and turned into cycle counts by expression.

package quad_adc_pkg;

    // ------------------------------------------------------------------
    // Widths and counts
    // ------------------------------------------------------------------
    localparam int CODE_W     = 10;            // Output code width per port.
    localparam int RAW_W      = 12;            // Signed raw conversion width per core.
    localparam int NUM_PORTS  = 4;             // Output ports A to D.
    localparam int SYNC_DEPTH = 2;             // Flip-flops in each synchroniser.

    // ------------------------------------------------------------------
    // Rate limits per channel in each mode, in Msps
    // ------------------------------------------------------------------
    localparam int RATE_4CH_MSPS = 1250;
    localparam int RATE_2CH_MSPS = 2500;
    localparam int RATE_1CH_MSPS = 5000;

    // ------------------------------------------------------------------
    // Code limits
    // ------------------------------------------------------------------
    localparam logic [CODE_W-1:0] CODE_TOP    = 10'h3FF;
    localparam logic [CODE_W-1:0] CODE_BOTTOM = 10'h000;
    localparam logic [CODE_W-1:0] CODE_MID    = 10'h200;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int LINK_PERIOD_PS          = 64000;   // Converter clock period in ps.
    localparam int STROBE_RESET_DELAY_PS   = 2500;    // Strobe reset delay, 2.5 ns typical.
    // Longest time rounds down, never below one edge of the strobe clock.
    localparam int STROBE_RESET_CYC =
        (STROBE_RESET_DELAY_PS / LINK_PERIOD_PS) < 1 ? 1
        : (STROBE_RESET_DELAY_PS / LINK_PERIOD_PS);
    localparam int RESYNC_MIN_WIDTH        = 2;       // Converter clock edges, least.

    // ------------------------------------------------------------------
    // Modes and selections
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        MODE_4CH,
        MODE_2CH,
        MODE_1CH
    } chan_mode_t;

    typedef logic [1:0] input_sel_t;    // 0 = A, 1 = B, 2 = C, 3 = D.

endpackage : quad_adc_pkg

/* File: verification/quad_adc_output_asserts.sv */
// Purpose: Concurrent checks on the converter output block.
// Assumes: Only the top ports are seen; two clock domains.
// Notes:   Attached to every instance by the bind below.
`timescale 1ns/1ps
module quad_adc_output_chk (
    // Clocks and reset
    input wire logic                               core_clk_i,
    input wire logic                               sys_rst_i,
    input wire logic                               conv_clk_i,
    // Resync pins and watched outputs
    input wire logic                               resync_in_pos_i,
    input wire logic                               resync_in_neg_i,
    input wire logic [quad_adc_pkg::CODE_W-1:0]    port_a_o,
    input wire logic [quad_adc_pkg::CODE_W-1:0]    port_d_o,
    input wire logic [quad_adc_pkg::NUM_PORTS-1:0] out_of_range_o,
    input wire logic                               data_ready_pos_o,
    input wire logic                               data_ready_neg_o,
    input wire logic                               resync_seen_o
);
    import quad_adc_pkg::*;
    // ------------------------------------------------------------
    // Helper: core cycles since the pins last showed a resync
    // ------------------------------------------------------------
    // Saturates so that a long quiet spell never wraps to a small count.
    logic [5:0] since_pin_reg;
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) since_pin_reg <= 6'h3F;
        else if (resync_in_pos_i && !resync_in_neg_i) since_pin_reg <= 6'h00;
        else if (since_pin_reg != 6'h3F) since_pin_reg <= since_pin_reg + 6'h01;
    end
    AST_STROBE_COMPL: assert property (@(posedge conv_clk_i) disable iff (sys_rst_i)
        data_ready_neg_o == !data_ready_pos_o) else $error("strobe legs disagree");
    AST_STROBE_FALLS: assert property (@(posedge conv_clk_i) disable iff (sys_rst_i)
        $rose(data_ready_pos_o) |-> ##[1:3] !data_ready_pos_o) else $error("strobe stuck high");
    AST_STROBE_RUNS: assert property (@(posedge conv_clk_i) disable iff (sys_rst_i)
        !data_ready_pos_o |-> ##[1:8] data_ready_pos_o) else $error("strobe stuck low");
    AST_PORT_A_EVEN: assert property (@(posedge conv_clk_i) disable iff (sys_rst_i)
        $changed(port_a_o) |=> $stable(port_a_o)) else $error("port a loaded twice in a row");
    AST_OOR_A: assert property (@(posedge conv_clk_i) disable iff (sys_rst_i)
        out_of_range_o[0] |-> port_a_o inside {10'h3FF, 10'h200, 10'h000})
        else $error("port a flag without end code");
    AST_OOR_D: assert property (@(posedge conv_clk_i) disable iff (sys_rst_i)
        out_of_range_o[3] |-> port_d_o inside {10'h3FF, 10'h200, 10'h000})
        else $error("port d flag without end code");
    AST_SEEN_PULSE: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        resync_seen_o |=> !resync_seen_o) else $error("resync pulse too long");
    AST_SEEN_CAUSE: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        resync_seen_o |-> since_pin_reg < 6'h18) else $error("resync seen without pins");
    COV_SEEN: cover property (@(posedge core_clk_i) resync_seen_o);
    COV_OOR: cover property (@(posedge conv_clk_i) out_of_range_o[0]);
    COV_STROBE: cover property (@(posedge conv_clk_i) $rose(data_ready_pos_o));
endmodule // quad_adc_output_chk

bind quad_adc_output quad_adc_output_chk u_quad_adc_output_chk (.core_clk_i, .sys_rst_i,
    .conv_clk_i, .resync_in_pos_i, .resync_in_neg_i, .port_a_o, .port_d_o, .out_of_range_o,
    .data_ready_pos_o, .data_ready_neg_o, .resync_seen_o);

/* File: verification/capture_model.sv */
// Purpose: Capture logic at the far side of the output ports.
// Assumes: Words are taken on the rising strobe edge.
// Notes:   Also drives the differential resync pins.
`timescale 1ns/1ps
module capture_model (
    // Link side
    input  wire logic                                 conv_clk_i,
    input  wire logic                                 data_ready_pos_i,
    input  wire logic [4*quad_adc_pkg::CODE_W-1:0]    ports_i,
    // Captured words and resync pins
    output logic      [4*quad_adc_pkg::CODE_W-1:0]    cap_o,
    output logic                                      resync_pos_o,
    output logic                                      resync_neg_o
);
    import quad_adc_pkg::*;
    // Latching on the strobe rise gives 1.5 periods of setup and half a period of hold in four channel mode.
    always @(posedge data_ready_pos_i) cap_o <= ports_i;
    initial begin
        resync_pos_o = 1'b0;
        resync_neg_o = 1'b1;
    end
    // Holds resync asserted across the given count of rising clock edges.
    task automatic pulse(input int edges);
        @(posedge conv_clk_i);
        resync_pos_o <= 1'b1;
        resync_neg_o <= 1'b0;
        repeat (edges) @(posedge conv_clk_i);
        resync_pos_o <= 1'b0;
        resync_neg_o <= 1'b1;
    endtask
endmodule // capture_model

/* File: verification/quad_adc_output_sync_routing_tb.sv */
// Purpose: Self-checking bench for the converter output block.
// Assumes: Inputs change on the core clock; outputs read once settled.
// Notes:   Every mode, pairing and selection is visited with random samples.
`timescale 1ns/1ps
module quad_adc_output_sync_routing_tb;
    import quad_adc_pkg::*;
    // ------------------------------------------------------------
    // Stimulus, design and far side
    // ------------------------------------------------------------
    logic                 core_clk_i = 1'b0;
    logic                 conv_clk_i = 1'b0;
    logic                 sys_rst_i = 1'b1;
    chan_mode_t           mode_i = MODE_4CH;
    logic                 pair_first_b_i = 1'b0;
    logic                 pair_second_d_i = 1'b0;
    input_sel_t           single_sel_i = 2'h0;
    logic                 gray_code_i = 1'b0;
    logic signed [RAW_W-1:0] raw_i [4] = '{default: '0};
    logic [CODE_W-1:0]    port_a_o, port_b_o, port_c_o, port_d_o;
    logic [NUM_PORTS-1:0] out_of_range_o;
    logic                 data_ready_pos_o, data_ready_neg_o, resync_seen_o, rs_pos, rs_neg;
    logic [39:0]          cap;
    logic [31:0]          lfsr = 32'hE5D521AC;
    int                   err_total = 0, checked = 0, seen_cnt = 0;
    int                   bnd [4] = '{511, 512, -512, -513};
    always #12.5 core_clk_i = ~core_clk_i;
    always #32 conv_clk_i = ~conv_clk_i;
    always @(posedge core_clk_i) if (resync_seen_o === 1'b1) seen_cnt++;
    quad_adc_output u_quad_adc_output (.core_clk_i, .sys_rst_i, .mode_i, .pair_first_b_i,
        .pair_second_d_i, .single_sel_i, .gray_code_i, .conv_clk_i, .raw_a_i(raw_i[0]),
        .raw_b_i(raw_i[1]), .raw_c_i(raw_i[2]), .raw_d_i(raw_i[3]), .resync_in_pos_i(rs_pos),
        .resync_in_neg_i(rs_neg), .port_a_o, .port_b_o, .port_c_o, .port_d_o, .out_of_range_o,
        .data_ready_pos_o, .data_ready_neg_o, .resync_seen_o);
    capture_model u_capture_model (.conv_clk_i, .data_ready_pos_i(data_ready_pos_o),
        .ports_i({port_d_o, port_c_o, port_b_o, port_a_o}), .cap_o(cap),
        .resync_pos_o(rs_pos), .resync_neg_o(rs_neg));
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic check(input logic [39:0] seen, input logic [39:0] exp);
        checked++;
        if (seen !== exp) begin
            err_total++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic stop_test;
        $display("Comparisons %0d, mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // A hang is cut short well past the expected run of about 36 us.
    initial begin
        #150us;
        err_total++;
        $display("Error at %0t: watchdog ran out", $time);
        stop_test;
    end
    // Mode code 3 is included so that the fallback to four channels is seen.
    initial begin
        int r [4];
        int v, m, src;
        logic g;
        logic [39:0] ev;
        logic [3:0] eo;
        repeat (10) @(posedge core_clk_i);
        sys_rst_i <= 1'b0;
        repeat (12) @(posedge core_clk_i);
        for (int i = 0; i < 32; i++) begin
            for (int k = 0; k < 4; k++) begin
                lfsr = lfsr_next(lfsr);
                r[k] = int'($signed(lfsr[10:0]));
            end
            if (i >= 16) r[3] = bnd[i % 4];
            g = lfsr[31];
            mode_i <= chan_mode_t'(i[1:0]);
            pair_first_b_i <= i[2];
            pair_second_d_i <= i[3];
            single_sel_i <= i[3:2];
            gray_code_i <= g;
            for (int k = 0; k < 4; k++) raw_i[k] <= RAW_W'(r[k]);
            repeat (40) @(posedge core_clk_i);
            m = i % 4;
            for (int p = 0; p < 4; p++) begin
                src = (m == 1) ? ((p < 2) ? i / 4 % 2 : 2 + i / 8 % 2)
                    : ((m == 2) ? i / 4 % 4 : p);
                v = r[src] + 512;
                eo[p] = (v > 1023) || (v < 0);
                v = (v < 0) ? 0 : ((v > 1023) ? 1023 : v);
                ev[p*10 +: 10] = g ? (v[9:0] ^ v[9:1]) : v[9:0];
            end
            check({port_d_o, port_c_o, port_b_o, port_a_o}, ev);
            check(40'(out_of_range_o), 40'(eo));
            check(cap, ev);
        end
        // One edge is too short; two and six edges each give a single resync.
        for (int j = 0; j < 3; j++) begin
            seen_cnt = 0;
            u_capture_model.pulse((j == 0) ? 1 : 4 * j - 2);
            repeat (40) @(posedge core_clk_i);
            check(40'(seen_cnt), 40'((j == 0) ? 0 : 1));
            check({port_d_o, port_c_o, port_b_o, port_a_o}, ev);
        end
        stop_test;
    end
endmodule // quad_adc_output_sync_routing_tb
